// File: lbx_pkg.sv
// How it works
// [RL1] Register extended branch target is program counter plus long source B.
// [RL2] Immediate branch target is program counter plus prefix-extended immediate.
// [RL3] Link flag writes current program counter to the long destination.
// [RL4] Delay flag lets the next instruction complete before the target. Code: lbx_fetch ignores delay_slot and goes straight to the target.
// [RL5] Without delay flag the target follows the branch directly.
// [RL6] Register branch takes two cycles with delay, three without.
// [RL7] Immediate branch: one cycle predicted; mispredict three, or seven to nine. Code: a mispredict with delay flag below area setting 2 takes two.
// [RL8] Without prefix the sixteen-bit immediate is sign-extended to sixty-four bits.
// [RL9] Linking register branch exists only with the delay flag set.
// [RL10] Register shift amount comes from bits 26 to 31 of register B.
// [RL11] Side flag set shifts left, clear shifts right.
// [RL12] Arithmetic right shift fills with source bit 0; zero amount copies.
// [RL13] Shifts take one cycle at area settings 0 or 2, two at 1.
// [RL14] Long shifts exist only when the barrel parameter equals one.
// [RL15] Immediate shift amount comes from instruction bits 26 to 31.
// [RL16] Extract takes a field of given width and position from source A.
// [RL17] Software keeps extract width 1 to 63 and width plus shift within 64.
// [RL18] Insert merges width field minus shift plus one bits into destination.
// [RL19] Extract or insert flag overrides the side and type flags.
// [RL20] Immediate shift and field instructions ignore any prefix.
// [RL21] Assembler encodes insert width field as shift plus width minus one.
// [RL22] Instructions are decoded by six-bit major opcode and fixed flag bits.
// [RL23] Program counter and long registers are 64 bits, additions wrap.
package lbx_pkg;
   localparam logic [5:0] OP_BR_REG = 6'h26;
   localparam logic [5:0] OP_BR_IMM = 6'h2E;
   localparam logic [5:0] OP_SH_REG = 6'h11;
   localparam logic [5:0] OP_SH_IMM = 6'h19;
   // Flag positions count from the word's least significant bit.
   localparam int BIT_D = 20;
   localparam int BIT_L = 18;
   localparam int BIT_S = 10;
   localparam int BIT_T = 9;
   localparam int BIT_I = 15;
   localparam int BIT_E = 14;
   localparam int BIT_IS = 5;
   localparam logic [3:0] BR_NODLY_CYC = 4'h3;
   localparam logic [3:0] BR_DLY_CYC = 4'h2;
   localparam logic [3:0] MISS_A0_CYC = 4'h3;
   localparam logic [3:0] MISS_A2_CYC = 4'h8;
   localparam logic [3:0] PRED_CYC = 4'h1;
   localparam logic [3:0] SH_CYC = 4'h1;
   localparam logic [3:0] SH_A1_CYC = 4'h2;
   localparam logic [63:0] PC_RST = 64'h0;
   typedef struct packed {
      logic [31:0] instr;
      logic [63:0] pc;
      logic [63:0] src_a;
      logic [63:0] src_b;
      logic [63:0] dst_old;
      logic pfx_valid;
      logic [63:0] pfx_value;
      logic pred_hit;
   } lbx_req_s;
   typedef struct packed {
      logic wr_en;
      logic [63:0] wr_data;
      logic redirect;
      logic [63:0] target;
      logic delay_slot;
   } lbx_rsp_s;
endpackage : lbx_pkg

// File: lbx_exec.sv
`timescale 1ns/1ps
module lbx_exec #(
   parameter int AREA_SETTING = 0,
   parameter int USE_BARREL = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic issue,
   input wire lbx_pkg::lbx_req_s req,
   output logic busy,
   output logic done,
   output lbx_pkg::lbx_rsp_s rsp
);
   typedef enum logic [1:0] {LBX_IDLE, LBX_WAIT} lbx_state_e;

   // Only one instruction is accepted while idle; busy stalls issue.
   lbx_state_e state_r;
   logic [3:0] cnt_r;
   logic [3:0] lat;
   lbx_pkg::lbx_rsp_s res;
   logic [5:0] op;
   logic [5:0] amt;
   logic [5:0] iw;
   logic [5:0] isft;
   logic [63:0] mask;
   logic [63:0] imm64;
   logic is_brr;
   logic is_bri;
   logic is_sh;
   logic known;

   function automatic logic [63:0] low_mask(input logic [6:0] n);
      low_mask = (n >= 7'd64) ? '1 : ((64'h1 << n) - 64'h1);
   endfunction : low_mask

   assign op = req.instr[31:26]; // [RL22]
   assign is_brr = (op == lbx_pkg::OP_BR_REG) && req.instr[16]; // [RL22]
   assign is_bri = (op == lbx_pkg::OP_BR_IMM) && req.instr[16]; // [RL22]
   assign is_sh = (USE_BARREL == 1) && ((op == lbx_pkg::OP_SH_REG)
                  || (op == lbx_pkg::OP_SH_IMM)); // [RL14]
   assign known = is_brr || is_bri || is_sh;
   assign iw = req.instr[11:6];
   assign isft = req.instr[5:0];
   // Prefix extends the branch immediate; otherwise plain sign extension.
   assign imm64 = req.pfx_valid ? req.pfx_value
                  : {{48{req.instr[15]}}, req.instr[15:0]}; // [RL2] [RL8]
   // Register form reads B bits 26..31, immediate form the own field only.
   assign amt = (op == lbx_pkg::OP_SH_REG) ? req.src_b[5:0] : req.instr[5:0]; // [RL10] [RL15] [RL20]
   assign mask = low_mask(7'(iw) - 7'(isft) + 7'd1) << isft; // [RL18]

   always_comb begin
      res = '0;
      lat = lbx_pkg::PRED_CYC;
      if (is_brr || is_bri) begin
         res.redirect = 1'b1;
         res.delay_slot = req.instr[lbx_pkg::BIT_D]; // [RL4] [RL5]
         // Linking without delay is not provided for the register form.
         res.wr_en = req.instr[lbx_pkg::BIT_L]
                     && (is_bri || req.instr[lbx_pkg::BIT_D]); // [RL3] [RL9]
         res.wr_data = req.pc; // [RL3]
         res.target = req.pc + (is_brr ? req.src_b : imm64); // [RL1] [RL2] [RL23]
         if (is_brr || !req.pred_hit) begin
            lat = req.instr[lbx_pkg::BIT_D] ? lbx_pkg::BR_DLY_CYC
                  : lbx_pkg::BR_NODLY_CYC; // [RL6]
         end
         if (is_bri && req.pred_hit) begin
            lat = lbx_pkg::PRED_CYC; // [RL7]
         end else if (is_bri && AREA_SETTING == 2) begin
            lat = lbx_pkg::MISS_A2_CYC; // [RL7]
         end else if (is_bri && req.instr[lbx_pkg::BIT_D] == 1'b0) begin
            lat = lbx_pkg::MISS_A0_CYC; // [RL7]
         end
      end else if (is_sh) begin
         res.wr_en = 1'b1;
         lat = (AREA_SETTING == 1) ? lbx_pkg::SH_A1_CYC : lbx_pkg::SH_CYC; // [RL13]
         if (op == lbx_pkg::OP_SH_IMM && req.instr[lbx_pkg::BIT_E]) begin
            res.wr_data = (req.src_a >> isft) & low_mask({1'b0, iw}); // [RL16] [RL19]
         end else if (op == lbx_pkg::OP_SH_IMM && req.instr[lbx_pkg::BIT_I]) begin
            res.wr_data = (req.dst_old & ~mask) | ((req.src_a << isft) & mask); // [RL18] [RL19]
         end else if (req.instr[lbx_pkg::BIT_S]) begin
            res.wr_data = req.src_a << amt; // [RL11]
         end else if (req.instr[lbx_pkg::BIT_T] && amt != 6'h0) begin
            res.wr_data = (req.src_a >> amt)
                          | ~({64{1'b1}} >> amt) & {64{req.src_a[63]}}; // [RL12]
         end else begin
            res.wr_data = req.src_a >> amt; // [RL11] [RL12]
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= LBX_IDLE;
         cnt_r <= 4'h0;
      end else begin
         case (state_r)
            LBX_IDLE: begin
               if (issue && known && lat > 4'h1) begin
                  state_r <= LBX_WAIT;
                  cnt_r <= lat - 4'h1; // [RL6] [RL7] [RL13]
               end
            end
            LBX_WAIT: begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1) begin
                  state_r <= LBX_IDLE;
               end
            end
            default: state_r <= LBX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp <= '0;
      end else if (state_r == LBX_IDLE && issue && known) begin
         rsp <= res;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
      end else begin
         done <= (state_r == LBX_IDLE && issue && known && lat == 4'h1)
                 || (state_r == LBX_WAIT && cnt_r == 4'h1);
      end
   end

   assign busy = (state_r != LBX_IDLE);

   chk_busy_bound: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(busy) |-> ##[1:8] !busy) else $error("busy too long"); // [RL7]
   chk_done_after: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(busy) |-> done) else $error("done missing at end"); // [RL6]
   // The register form has no linking variant without a delay slot.
   chk_link_suppressed: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
      (state_r == LBX_IDLE && issue && is_brr && !req.instr[lbx_pkg::BIT_D]) |=> !rsp.wr_en)
      else $error("link write without delay slot");
   chk_pred_single: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
      (state_r == LBX_IDLE && issue && is_bri && req.pred_hit) |=> (done && rsp.redirect))
      else $error("predicted branch not single cycle");
   chk_shift_single: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
      (state_r == LBX_IDLE && issue && is_sh && AREA_SETTING != 1) |=> done)
      else $error("shift not single cycle");
   chk_rsp_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RL22]
      !(state_r == LBX_IDLE && issue && known) |=> $stable(rsp))
      else $error("response changed without accepted op");
endmodule : lbx_exec

// File: lbx_fetch.sv
`timescale 1ns/1ps
module lbx_fetch (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic done,
   input wire lbx_pkg::lbx_rsp_s rsp,
   output logic [63:0] pc
);
   // Fetch jumps to a redirect target, else steps one word; the sum wraps.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pc <= 64'h0000_0000_0000_1000;
      else if (done) pc <= rsp.redirect ? rsp.target : pc + 64'h4;
   end
endmodule : lbx_fetch

// File: lbx_exec_tb.sv
`timescale 1ns/1ps
module lbx_exec_tb;
   logic clk = 0;
   logic rst_n = 0;
   logic issue = 0;
   logic busy, done, s, t, bz;
   logic [63:0] pc, p, n, e;
   lbx_pkg::lbx_req_s req = '0;
   lbx_pkg::lbx_rsp_s rsp;
   int errors = 0;
   int total_checks = 0;
   int cyc = 0;
   localparam logic [63:0] A = 64'h8421_0000_0000_00F1;
   lbx_exec i_dut (.clk(clk), .rst_n(rst_n), .issue(issue), .req(req), .busy(busy),
      .done(done), .rsp(rsp));
   lbx_fetch i_fetch (.clk(clk), .rst_n(rst_n), .done(done), .rsp(rsp), .pc(pc));
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         stop_test();
      end
   end
   task stop_test;
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task chk(input logic [63:0] sn, input logic [63:0] ex);
      total_checks++;
      if (sn !== ex) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, sn, ex);
      end
   endtask : chk
   function automatic logic [31:0] br(logic [5:0] o, logic d, logic l, logic [15:0] lo);
      return {o, 5'h03, d, 1'b0, l, 1'b0, 1'b1, lo};
   endfunction : br
   // Issue one op, count edges to done; the extra edge lets fetch settle.
   task automatic op(input logic [31:0] in, input logic [63:0] a, b, d, pf, input logic h);
      @(posedge clk);
      p = pc;
      req <= '{in, pc, a, b, d, pf != 0, pf, h};
      issue <= 1'b1;
      @(posedge clk);
      issue <= 1'b0;
      n = 1;
      #1;
      bz = busy;
      while (done !== 1'b1 && n < 12) begin
         @(posedge clk);
         #1 n++;
      end
      @(posedge clk);
   endtask : op
   task s_reg_br;
      op(br(lbx_pkg::OP_BR_REG, 1, 1, 16'h2000), 0, -64'h2000, 0, 0, 1);
      chk(n, 2);
      chk(bz, 1);
      chk({rsp.wr_en, rsp.delay_slot}, 3);
      chk(rsp.wr_data, p);
      #1 chk(pc, p - 64'h2000);
      op(br(lbx_pkg::OP_BR_REG, 0, 1, 16'h2000), 0, 64'h40, 0, 0, 1);
      chk(n, 3);
      chk({rsp.wr_en, rsp.delay_slot}, 0);
      chk(rsp.target, p + 64'h40);
   endtask : s_reg_br
   task s_imm_br;
      op(br(lbx_pkg::OP_BR_IMM, 0, 0, 16'h8000), 0, 0, 0, 0, 1);
      chk(n, 1);
      chk(rsp.target, p + 64'hFFFF_FFFF_FFFF_8000);
      op(br(lbx_pkg::OP_BR_IMM, 0, 1, 16'h0010), 0, 0, 0, 64'h1_0000_0010, 0);
      chk(n, 3);
      chk(rsp.target, p + 64'h1_0000_0010);
      chk(rsp.wr_en, 1);
      chk(rsp.wr_data, p);
   endtask : s_imm_br
   task s_shift;
      for (int k = 0; k < 3; k++) begin
         s = (k == 0);
         t = (k == 2);
         e = s ? A << 4 : t ? 64'($signed(A) >>> 4) : A >> 4;
         op({lbx_pkg::OP_SH_REG, 15'h0C85, s, t, 9'h100}, A, 64'hFFC4, 0, 0, 1);
         chk(rsp.wr_data, e);
         chk(n, 1);
         chk(bz, 0);
         e = s ? A << 7 : t ? 64'($signed(A) >>> 7) : A >> 7;
         op({lbx_pkg::OP_SH_IMM, 15'h0C84, s, t, 9'h007}, A, 5, 0, 64'hDEAD, 1);
         chk(rsp.wr_data, e);
      end
      op({lbx_pkg::OP_SH_IMM, 15'h0C84, 2'b01, 9'h000}, A, 0, 0, 0, 1);
      chk(rsp.wr_data, A);
   endtask : s_shift
   task s_field;
      op({lbx_pkg::OP_SH_IMM, 10'h064, 4'h6, 6'd8, 6'd56}, A, 0, 0, 0, 1);
      chk(rsp.wr_data, 64'h84);
      op({lbx_pkg::OP_SH_IMM, 10'h064, 4'hA, 6'd15, 6'd8}, A, 0, {16{4'h5}}, 0, 1);
      chk(rsp.wr_data, 64'h5555_5555_5555_F155);
      op(32'hFC00_0000, A, 0, 0, 0, 1);
      chk(n, 12);
   endtask : s_field
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      s_reg_br();
      s_imm_br();
      s_shift();
      s_field();
      stop_test();
   end
endmodule : lbx_exec_tb
